// ==== design/hcs_pkg.sv ====
// Package for the heatseal cycle sequencer: register map, fields, timing, types
package hcs_pkg;

	// Timing at 10 MHz pclk
	localparam int unsigned CLK_HZ        = 10000000;
	localparam int unsigned TICK_MS       = 100;
	localparam int unsigned TICK_CYC      = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned PULSE_MS      = 500;
	localparam int unsigned PULSE_TICKS   = PULSE_MS / TICK_MS;
	localparam int unsigned BLINK_MS      = 500;
	localparam int unsigned BLINK_TICKS   = BLINK_MS / TICK_MS;

	// Setting limits and defaults, tenths of a second or degrees / percent
	localparam logic [9:0]  DELAY_MAX      = 10'h063;
	localparam logic [9:0]  SEAL_DEF       = 10'h00a;
	localparam logic [9:0]  COOL_TIME_MAX  = 10'h3e7;
	localparam logic [9:0]  COOL_TIME_DEF  = 10'h064;
	localparam logic [9:0]  COOL_ABS_MIN   = 10'h032;
	localparam logic [9:0]  COOL_REL_MIN   = 10'h028;
	localparam logic [9:0]  COOL_REL_MAX   = 10'h064;
	localparam logic [6:0]  REACH_PCT      = 7'h5f;
	localparam logic [6:0]  PCT_FULL       = 7'h64;

	// APB register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_TIMES  = 8'h04;
	localparam logic [7:0] OFS_COOL   = 8'h08;
	localparam logic [7:0] OFS_TEMP   = 8'h0c;
	localparam logic [7:0] OFS_ALARM  = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_ALEVEL = 8'h18;

	// Alarm codes as stored by software in the alarm register
	localparam logic [9:0] ERR_NONE = 10'h000;

	// Analog full scale code (10 V)
	localparam logic [11:0] ANA_FULL = 12'hfff;

	typedef enum logic [1:0] {
		HCS_COOL_ABS  = 2'h0,
		HCS_COOL_REL  = 2'h1,
		HCS_COOL_TIME = 2'h2
	} hcs_cool_t;

	typedef enum logic [1:0] {
		HCS_RLY_START = 2'h0,
		HCS_RLY_TEMP  = 2'h1,
		HCS_RLY_COOL  = 2'h2,
		HCS_RLY_PULSE = 2'h3
	} hcs_rly_t;

	typedef enum logic [4:0] {
		HCS_IDLE  = 5'b00001,
		HCS_DELAY = 5'b00010,
		HCS_HEAT  = 5'b00100,
		HCS_COOL  = 5'b01000,
		HCS_DONE  = 5'b10000
	} hcs_state_t;

	// Control register
	typedef struct packed {
		logic       time_on;
		logic       seal_at_heat;
		hcs_cool_t  cool_mode;
		hcs_rly_t   rly_mode;
		logic       alarm_inv;
		logic       aux_fixed;
	} hcs_ctrl_t;

	// Machine inputs after synchronising
	typedef struct packed {
		logic start;
		logic reset;
		logic key_reset;
		logic request_a;
	} hcs_pins_t;

	// Whole block state
	typedef struct packed {
		hcs_ctrl_t   ctrl;
		logic [9:0]  delay;
		logic [9:0]  seal;
		logic [9:0]  cool_val;
		logic [9:0]  setpoint;
		logic [9:0]  actual;
		logic [9:0]  request_a_t;
		logic [9:0]  err_code;
		logic        err_flash;
		logic [11:0] err_level;
		logic [11:0] temp_level;
		hcs_pins_t   s1;
		hcs_pins_t   s2;
		logic        start_old;
		hcs_state_t  st;
		logic [23:0] pre;
		logic [9:0]  ticks;
		logic        sealing;
		logic        aux;
		logic [2:0]  pulse;
		logic        hold;
		logic        blink;
		logic [2:0]  bcnt;
		logic [31:0] prdata;
	} hcs_state_s_t;

endpackage : hcs_pkg

// ==== design/hcs_sequencer.sv ====
// Heatseal cycle sequencer with APB register file
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module hcs_sequencer (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Machine control pins
	input  wire logic        start_in,
	input  wire logic        reset_in,
	input  wire logic        key_reset,
	input  wire logic        request_a,
	// Outputs
	output logic             heat_on,
	output logic             request_a_on,
	output logic             aux_relay,
	output logic             alarm_relay,
	output logic      [11:0] analog_out
);

	hcs_pkg::hcs_state_s_t q, d;

	logic        wr, rd, hit;
	logic        tick, start_rise, reached, clr;
	logic [16:0] t_pct, s_pct;
	logic        cool_done, calib_err;
	logic        alm;
	logic [31:0] rdv;

	// Zero wait states: every access ends in its first access cycle
	assign pready  = 1'b1;
	assign wr      = psel & penable & pwrite;
	// Read data latched at the setup edge, so it stands through the access phase
	assign rd      = psel & ~penable & ~pwrite;
	assign hit     = (paddr == hcs_pkg::OFS_CTRL) | (paddr == hcs_pkg::OFS_TIMES)
		| (paddr == hcs_pkg::OFS_COOL) | (paddr == hcs_pkg::OFS_TEMP)
		| (paddr == hcs_pkg::OFS_ALARM) | (paddr == hcs_pkg::OFS_STATUS)
		| (paddr == hcs_pkg::OFS_ALEVEL);
	assign pslverr = psel & penable & ~hit;
	assign prdata  = q.prdata;

	// Event and comparison terms
	assign tick       = (q.pre == 24'(hcs_pkg::TICK_CYC - 1));
	assign start_rise = q.s2.start & ~q.start_old;
	assign t_pct      = 17'(q.actual) * 17'(hcs_pkg::PCT_FULL);
	assign s_pct      = 17'(q.setpoint) * 17'(hcs_pkg::REACH_PCT);
	assign reached    = t_pct >= s_pct;
	assign calib_err  = (q.err_code != hcs_pkg::ERR_NONE) & q.err_flash;
	assign alm        = q.err_code != hcs_pkg::ERR_NONE;
	assign clr        = q.s2.reset | q.s2.key_reset;

	// Cooling end criterion
	always_comb begin
		unique case (q.ctrl.cool_mode)
			hcs_pkg::HCS_COOL_REL:
				cool_done = 17'(q.actual) * 17'(hcs_pkg::PCT_FULL)
					<= 17'(q.setpoint) * 17'(q.cool_val);
			hcs_pkg::HCS_COOL_TIME:
				cool_done = q.ticks >= q.cool_val;
			default:
				cool_done = q.actual < q.cool_val;
		endcase
		// In absolute mode request_a holds the band above this; never end
		if (q.ctrl.cool_mode != hcs_pkg::HCS_COOL_TIME && q.s2.request_a
			&& q.cool_val <= q.request_a_t && q.ctrl.cool_mode == hcs_pkg::HCS_COOL_ABS)
			cool_done = 1'b0;
	end

	// Read mux
	always_comb begin
		rdv = 32'h0000_0000;
		unique case (paddr)
			hcs_pkg::OFS_CTRL:   rdv = 32'(q.ctrl);
			hcs_pkg::OFS_TIMES:  rdv = {12'h000, q.seal, q.delay};
			hcs_pkg::OFS_COOL:   rdv = {22'h000000, q.cool_val};
			hcs_pkg::OFS_TEMP:   rdv = {2'h0, q.request_a_t, q.actual, q.setpoint};
			hcs_pkg::OFS_ALARM:  rdv = {21'h000000, q.err_flash, q.err_code};
			hcs_pkg::OFS_STATUS: rdv = {23'h000000, q.aux, q.sealing, q.hold,
				q.st, q.ticks[0]};
			hcs_pkg::OFS_ALEVEL: rdv = {8'h00, q.temp_level, q.err_level};
			default:             rdv = 32'h0000_0000;
		endcase
	end

	// Next state
	always_comb begin
		d = q;
		d.s1.start     = start_in;
		d.s1.reset     = reset_in;
		d.s1.key_reset = key_reset;
		d.s1.request_a = request_a;
		d.s2           = q.s1;
		d.start_old    = q.s2.start;
		d.prdata       = rd ? rdv : q.prdata;
		d.pre          = tick ? 24'h000000 : q.pre + 24'h000001;

		// Clear first, so a write or start in the same cycle still lands
		if (clr) begin
			d.err_code  = hcs_pkg::ERR_NONE;
			d.err_flash = 1'b0;
			d.hold      = 1'b0;
		end

		// Register writes
		if (wr) begin
			unique case (paddr)
				hcs_pkg::OFS_CTRL: begin
					d.ctrl = pwdata[$bits(hcs_pkg::hcs_ctrl_t)-1:0];
					if (d.ctrl.cool_mode != q.ctrl.cool_mode) begin
						unique case (d.ctrl.cool_mode)
							hcs_pkg::HCS_COOL_REL:  d.cool_val = hcs_pkg::COOL_REL_MIN;
							hcs_pkg::HCS_COOL_TIME: d.cool_val = hcs_pkg::COOL_TIME_DEF;
							default:                d.cool_val = hcs_pkg::COOL_ABS_MIN;
						endcase
					end
				end
				hcs_pkg::OFS_TIMES: begin
					d.delay = (pwdata[9:0] > hcs_pkg::DELAY_MAX) ? hcs_pkg::DELAY_MAX
						: pwdata[9:0];
					d.seal  = (pwdata[19:10] > hcs_pkg::COOL_TIME_MAX)
						? hcs_pkg::COOL_TIME_MAX : pwdata[19:10];
				end
				hcs_pkg::OFS_COOL: begin
					unique case (q.ctrl.cool_mode)
						hcs_pkg::HCS_COOL_REL:
							d.cool_val = (pwdata[9:0] < hcs_pkg::COOL_REL_MIN)
								? hcs_pkg::COOL_REL_MIN
								: (pwdata[9:0] > hcs_pkg::COOL_REL_MAX)
								? hcs_pkg::COOL_REL_MAX : pwdata[9:0];
						hcs_pkg::HCS_COOL_TIME:
							d.cool_val = (pwdata[9:0] > hcs_pkg::COOL_TIME_MAX)
								? hcs_pkg::COOL_TIME_MAX : pwdata[9:0];
						default:
							d.cool_val = (pwdata[9:0] < hcs_pkg::COOL_ABS_MIN)
								? hcs_pkg::COOL_ABS_MIN : pwdata[9:0];
					endcase
				end
				hcs_pkg::OFS_TEMP: begin
					d.setpoint  = pwdata[9:0];
					d.actual    = pwdata[19:10];
					d.request_a_t = pwdata[29:20];
				end
				hcs_pkg::OFS_ALARM: begin
					d.err_code  = pwdata[9:0];
					d.err_flash = pwdata[10];
				end
				hcs_pkg::OFS_ALEVEL: begin
					d.err_level  = pwdata[11:0];
					d.temp_level = pwdata[23:12];
				end
				default: ;
			endcase
		end

		// Sequencer
		if (tick)
			d.ticks = q.ticks + 10'h001;
		unique case (q.st)
			hcs_pkg::HCS_IDLE: begin
				if (q.ctrl.time_on && start_rise) begin
					d.ticks   = 10'h000;
					d.sealing = 1'b0;
					d.st      = hcs_pkg::HCS_DELAY;
				end
			end
			hcs_pkg::HCS_DELAY: begin
				if (q.ticks >= q.delay) begin
					d.ticks   = 10'h000;
					d.sealing = q.ctrl.seal_at_heat;
					d.st      = hcs_pkg::HCS_HEAT;
				end
			end
			hcs_pkg::HCS_HEAT: begin
				if (!q.sealing) begin
					d.ticks = 10'h000;
					if (reached)
						d.sealing = 1'b1;
				end else if (q.ticks >= q.seal) begin
					d.ticks   = 10'h000;
					d.sealing = 1'b0;
					d.st      = hcs_pkg::HCS_COOL;
				end
			end
			hcs_pkg::HCS_COOL: begin
				if (cool_done)
					d.st = hcs_pkg::HCS_DONE;
			end
			hcs_pkg::HCS_DONE: begin
				d.st = hcs_pkg::HCS_IDLE;
			end
		endcase
		if (q.s2.reset) begin
			d.st      = hcs_pkg::HCS_IDLE;
			d.sealing = 1'b0;
		end

		// Auxiliary relay
		if (!q.ctrl.time_on) begin
			d.aux   = q.ctrl.aux_fixed;
			d.pulse = 3'h0;
		end else begin
			unique case (q.ctrl.rly_mode)
				hcs_pkg::HCS_RLY_START:
					d.aux = (d.st != hcs_pkg::HCS_IDLE) && (d.st != hcs_pkg::HCS_DONE);
				hcs_pkg::HCS_RLY_TEMP:
					d.aux = (d.st == hcs_pkg::HCS_IDLE || d.st == hcs_pkg::HCS_DONE) ? 1'b0
						: (q.aux | ((q.st == hcs_pkg::HCS_HEAT) & reached));
				hcs_pkg::HCS_RLY_COOL:
					d.aux = d.st == hcs_pkg::HCS_COOL;
				hcs_pkg::HCS_RLY_PULSE: begin
					if (q.st == hcs_pkg::HCS_COOL && d.st == hcs_pkg::HCS_DONE) begin
						d.aux   = 1'b1;
						d.pulse = 3'h0;
					end else if (q.aux && (start_rise
						|| q.pulse == 3'(hcs_pkg::PULSE_TICKS))) begin
						d.aux = 1'b0;
					end else if (q.aux && tick) begin
						d.pulse = q.pulse + 3'h1;
					end
				end
			endcase
		end

		// Alarm hold and 1 Hz flash
		if (tick) begin
			if (q.bcnt == 3'(hcs_pkg::BLINK_TICKS - 1)) begin
				d.bcnt  = 3'h0;
				d.blink = ~q.blink;
			end else begin
				d.bcnt = q.bcnt + 3'h1;
			end
		end
		if (calib_err && start_rise)
			d.hold = 1'b1;
		if (!alm)
			d.hold = 1'b0;
	end

	// Request_a gate, heat drive and alarm relay
	always_comb begin
		heat_on     = q.st == hcs_pkg::HCS_HEAT;
		request_a_on  = q.s2.request_a & (!q.ctrl.time_on || q.st != hcs_pkg::HCS_HEAT);
		aux_relay   = q.aux;
		// Unless alarm_inv is set, calibration codes open until start; others close
		alarm_relay = (alm & (!q.err_flash | q.hold)) ^ (alm & q.ctrl.alarm_inv);
		if (!alm)
			analog_out = q.temp_level;
		else if (calib_err && !q.hold && q.blink)
			analog_out = hcs_pkg::ANA_FULL;
		else
			analog_out = q.err_level;
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q                <= '0;
			q.ctrl.cool_mode <= hcs_pkg::HCS_COOL_ABS;
			q.ctrl.rly_mode  <= hcs_pkg::HCS_RLY_TEMP;
			q.cool_val       <= hcs_pkg::COOL_ABS_MIN;
			q.seal           <= hcs_pkg::SEAL_DEF;
			q.st             <= hcs_pkg::HCS_IDLE;
		end else begin
			q <= d;
		end
	end

	// Pulse mode releases the relay within its window
	pulse_len_a: assert property (@(posedge pclk) disable iff (!presetn)
		(q.ctrl.time_on && q.ctrl.rly_mode == hcs_pkg::HCS_RLY_PULSE && q.pulse == 3'h6)
		|-> !q.aux) else $error("pulse overran");
	// Reset input aborts a cycle
	abort_a: assert property (@(posedge pclk) disable iff (!presetn)
		q.s2.reset |=> q.st == hcs_pkg::HCS_IDLE) else $error("abort failed");
	// No request_a while heating under time control
	request_a_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		(q.ctrl.time_on && q.st == hcs_pkg::HCS_HEAT) |-> !request_a_on)
		else $error("request_a in heat");
	// Alarm cleared after reset input
	alarm_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clr && !(wr && paddr == hcs_pkg::OFS_ALARM)) |=> q.err_code == hcs_pkg::ERR_NONE)
		else $error("alarm kept");
	// Cooling relay follows cooling phase
	cool_relay_a: assert property (@(posedge pclk) disable iff (!presetn)
		(q.ctrl.time_on && $stable(q.ctrl) && q.ctrl.rly_mode == hcs_pkg::HCS_RLY_COOL
		&& $past(q.ctrl.time_on)) |-> q.aux == (q.st == hcs_pkg::HCS_COOL))
		else $error("cool relay");
	// Non-timed relay follows fixed setting
	fixed_relay_a: assert property (@(posedge pclk) disable iff (!presetn)
		!q.ctrl.time_on |=> aux_relay == $past(q.ctrl.aux_fixed))
		else $error("relay not fixed");
	// Held flash shows error level steadily
	hold_level_a: assert property (@(posedge pclk) disable iff (!presetn)
		(q.hold && alm) |-> analog_out == q.err_level) else $error("hold lost");
	// Heating preceded by delay state
	seq_order_a: assert property (@(posedge pclk) disable iff (!presetn)
		(q.st == hcs_pkg::HCS_HEAT && $past(q.st) != hcs_pkg::HCS_HEAT)
		|-> $past(q.st) == hcs_pkg::HCS_DELAY) else $error("bad order");

endmodule : hcs_sequencer
`default_nettype wire

// ==== verification/hcs_machine_model.sv ====
// Machine controller model driving the sequencer's control pins
`timescale 1ns/1ps
`default_nettype none

module hcs_machine_model (
	// Clock
	input  wire logic pclk,
	// Control pins
	output var logic  start_in,
	output var logic  reset_in,
	output var logic  key_reset,
	output var logic  request_a
);
	// All pins idle at power-up
	initial begin
		start_in  = 1'b0;
		reset_in  = 1'b0;
		key_reset = 1'b0;
		request_a = 1'b0;
	end

	// Levels change just after an edge, as a PLC output would
	task automatic set_start(input logic v);
		@(posedge pclk);
		start_in <= v;
	endtask : set_start

	task automatic set_req(input logic v);
		@(posedge pclk);
		request_a <= v;
	endtask : set_req

	// Pulse held long enough to pass the two-flop synchroniser
	task automatic pulse_reset(input logic key);
		@(posedge pclk);
		if (key) begin
			key_reset <= 1'b1;
		end else begin
			reset_in <= 1'b1;
		end
		repeat (5) @(posedge pclk);
		key_reset <= 1'b0;
		reset_in  <= 1'b0;
	endtask : pulse_reset
endmodule : hcs_machine_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking testbench for the heatseal cycle sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        start_in;
	logic        reset_in;
	logic        key_reset;
	logic        request_a;
	logic        heat_on;
	logic        request_a_on;
	logic        aux_relay;
	logic        alarm_relay;
	logic [11:0] analog_out;
	logic [31:0] rdat;
	logic        serr;
	int          num_errors = 0;
	int          n_tests = 0;
	int          cyc = 0;

	hcs_sequencer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .start_in(start_in), .reset_in(reset_in), .key_reset(key_reset),
		.request_a(request_a), .heat_on(heat_on), .request_a_on(request_a_on),
		.aux_relay(aux_relay), .alarm_relay(alarm_relay), .analog_out(analog_out));

	hcs_machine_model i_mach (.pclk(pclk), .start_in(start_in), .reset_in(reset_in),
		.key_reset(key_reset), .request_a(request_a));

	// 10 MHz clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("Checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// One APB transfer; data and response taken at the edge that sees pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		serr = pslverr;
		rdat = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
		// One idle edge so outputs of a write have settled on return
		@(posedge pclk);
	endtask : apb

	task automatic t_reset();
		apb(1'b0, hcs_pkg::OFS_CTRL, 32'h0);
		chk("ctrl", rdat, 32'h00000004);
		apb(1'b0, hcs_pkg::OFS_TIMES, 32'h0);
		chk("times", rdat, {12'h000, hcs_pkg::SEAL_DEF, 10'h000});
		apb(1'b0, hcs_pkg::OFS_COOL, 32'h0);
		chk("cool", rdat, {22'h0, hcs_pkg::COOL_ABS_MIN});
		apb(1'b0, hcs_pkg::OFS_STATUS, 32'h0);
		chk("state", {27'h0, rdat[5:1]}, {27'h0, hcs_pkg::HCS_IDLE});
	endtask : t_reset

	task automatic t_regs();
		logic [1:0] md [3] = '{2'h1, 2'h2, 2'h0};
		logic [9:0] dv [3] = '{hcs_pkg::COOL_REL_MIN, hcs_pkg::COOL_TIME_DEF, hcs_pkg::COOL_ABS_MIN};
		logic [9:0] wv [3] = '{10'h3ff, 10'h3ff, 10'h000};
		logic [9:0] ev [3] = '{hcs_pkg::COOL_REL_MAX, hcs_pkg::COOL_TIME_MAX, hcs_pkg::COOL_ABS_MIN};
		apb(1'b1, hcs_pkg::OFS_TIMES, 32'h000028c8);
		apb(1'b0, hcs_pkg::OFS_TIMES, 32'h0);
		chk("delay", {22'h0, rdat[9:0]}, {22'h0, hcs_pkg::DELAY_MAX});
		apb(1'b1, 8'h1c, 32'h1);
		chk("slverr", {31'h0, serr}, 32'h1);
		// Each mode change must reload the cooling value, then clamp
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, hcs_pkg::OFS_CTRL, {26'h0, md[i], 4'h4});
			apb(1'b0, hcs_pkg::OFS_COOL, 32'h0);
			chk("cool reload", rdat, {22'h0, dv[i]});
			apb(1'b1, hcs_pkg::OFS_COOL, {22'h0, wv[i]});
			apb(1'b0, hcs_pkg::OFS_COOL, 32'h0);
			chk("cool clamp", rdat, {22'h0, ev[i]});
		end
		apb(1'b1, hcs_pkg::OFS_TIMES, 32'h00002800);
	endtask : t_regs

	task automatic t_alarm();
		logic [9:0] cd [6] = '{10'h065, 10'h0c9, 10'h321, 10'h068, 10'h0d3, 10'h06f};
		logic       fl;
		apb(1'b1, hcs_pkg::OFS_ALEVEL, 32'h000aa155);
		chk("temp level", {20'h0, analog_out}, 32'h000000aa);
		for (int inv = 0; inv < 2; inv++) begin
			apb(1'b1, hcs_pkg::OFS_CTRL, {30'h1, inv[0], 1'b0});
			for (int i = 0; i < 6; i++) begin
				fl = (i > 2);
				apb(1'b1, hcs_pkg::OFS_ALARM, {21'h0, fl, cd[i]});
				chk("alarm relay", {31'h0, alarm_relay}, {31'h0, ~fl ^ inv[0]});
				if (!fl) begin
					chk("err level", {20'h0, analog_out}, 32'h00000155);
				end else begin
					chk("flash level", {31'h0, analog_out === 12'h155 || analog_out === 12'hfff},
						32'h1);
				end
			end
			i_mach.pulse_reset(1'b0);
			apb(1'b0, hcs_pkg::OFS_ALARM, 32'h0);
			chk("clear by input", {22'h0, rdat[9:0]}, 32'h0);
		end
		// Start while flashing: relay closes and the level freezes
		apb(1'b1, hcs_pkg::OFS_CTRL, 32'h00000004);
		apb(1'b1, hcs_pkg::OFS_ALARM, 32'h00000468);
		i_mach.set_start(1'b1);
		repeat (8) @(posedge pclk);
		chk("start closes", {31'h0, alarm_relay}, 32'h1);
		apb(1'b0, hcs_pkg::OFS_STATUS, 32'h0);
		chk("hold", {31'h0, rdat[6]}, 32'h1);
		chk("frozen", {20'h0, analog_out}, 32'h00000155);
		i_mach.set_start(1'b0);
		i_mach.pulse_reset(1'b1);
		apb(1'b0, hcs_pkg::OFS_ALARM, 32'h0);
		chk("clear by key", {22'h0, rdat[9:0]}, 32'h0);
	endtask : t_alarm

	// Start-signal relay, sealing with heating, request_a gating, abort
	task automatic t_cycle();
		i_mach.set_req(1'b1);
		apb(1'b1, hcs_pkg::OFS_CTRL, 32'h000000c0);
		i_mach.set_start(1'b1);
		repeat (8) @(posedge pclk);
		apb(1'b0, hcs_pkg::OFS_STATUS, 32'h0);
		chk("heat state", {27'h0, rdat[5:1]}, {27'h0, hcs_pkg::HCS_HEAT});
		chk("sealing", {31'h0, rdat[7]}, 32'h1);
		chk("aux start", {31'h0, aux_relay}, 32'h1);
		chk("heat", {31'h0, heat_on}, 32'h1);
		chk("request_a off", {31'h0, request_a_on}, 32'h0);
		i_mach.set_start(1'b0);
		i_mach.pulse_reset(1'b0);
		repeat (4) @(posedge pclk);
		apb(1'b0, hcs_pkg::OFS_STATUS, 32'h0);
		chk("abort", {27'h0, rdat[5:1]}, {27'h0, hcs_pkg::HCS_IDLE});
		chk("heat off", {31'h0, heat_on}, 32'h0);
	endtask : t_cycle

	// Sealing timer and relay wait for 95 percent; 189 of 200 is short
	task automatic t_temp();
		apb(1'b1, hcs_pkg::OFS_CTRL, 32'h00000084);
		apb(1'b1, hcs_pkg::OFS_TEMP, 32'h0002f4c8);
		i_mach.set_start(1'b1);
		repeat (8) @(posedge pclk);
		apb(1'b0, hcs_pkg::OFS_STATUS, 32'h0);
		chk("seal wait", {31'h0, rdat[7]}, 32'h0);
		chk("aux wait", {31'h0, aux_relay}, 32'h0);
		apb(1'b1, hcs_pkg::OFS_TEMP, 32'h0002f8c8);
		apb(1'b0, hcs_pkg::OFS_STATUS, 32'h0);
		chk("seal go", {31'h0, rdat[7]}, 32'h1);
		chk("aux go", {31'h0, aux_relay}, 32'h1);
		i_mach.set_start(1'b0);
		i_mach.pulse_reset(1'b0);
	endtask : t_temp

	// Without time control start is ignored and the relay is fixed
	task automatic t_notimed();
		apb(1'b1, hcs_pkg::OFS_CTRL, 32'h00000001);
		i_mach.set_start(1'b1);
		repeat (8) @(posedge pclk);
		chk("aux fixed", {31'h0, aux_relay}, 32'h1);
		apb(1'b0, hcs_pkg::OFS_STATUS, 32'h0);
		chk("no cycle", {27'h0, rdat[5:1]}, {27'h0, hcs_pkg::HCS_IDLE});
		i_mach.set_start(1'b0);
	endtask : t_notimed

	// Cooling end, request_a lock-out, cooling relay and end-of-cycle pulse
	task automatic t_cool();
		apb(1'b1, hcs_pkg::OFS_TIMES, 32'h00000000);
		apb(1'b1, hcs_pkg::OFS_TEMP, {2'h0, 10'h000, 10'h0be, 10'h0c8});
		apb(1'b1, hcs_pkg::OFS_CTRL, 32'h000000c8);
		i_mach.set_start(1'b1);
		repeat (8) @(posedge pclk);
		apb(1'b0, hcs_pkg::OFS_STATUS, 32'h0);
		chk("cool state", {27'h0, rdat[5:1]}, {27'h0, hcs_pkg::HCS_COOL});
		chk("aux cool", {31'h0, aux_relay}, 32'h1);
		chk("request_a cool", {31'h0, request_a_on}, 32'h1);
		// In absolute mode a cooling value at or below request_a never ends the phase
		apb(1'b1, hcs_pkg::OFS_TEMP, {2'h0, 10'h03c, 10'h031, 10'h0c8});
		repeat (2) @(posedge pclk);
		apb(1'b0, hcs_pkg::OFS_STATUS, 32'h0);
		chk("request_a lock", {27'h0, rdat[5:1]}, {27'h0, hcs_pkg::HCS_COOL});
		apb(1'b1, hcs_pkg::OFS_TEMP, {2'h0, 10'h000, 10'h031, 10'h0c8});
		repeat (2) @(posedge pclk);
		apb(1'b0, hcs_pkg::OFS_STATUS, 32'h0);
		chk("cool end", {27'h0, rdat[5:1]}, {27'h0, hcs_pkg::HCS_IDLE});
		chk("aux open", {31'h0, aux_relay}, 32'h0);
		// Pulse mode: closes at cycle end, a new start opens it at once
		apb(1'b1, hcs_pkg::OFS_CTRL, 32'h000000cc);
		apb(1'b1, hcs_pkg::OFS_TEMP, {2'h0, 10'h000, 10'h0be, 10'h0c8});
		i_mach.set_start(1'b0);
		i_mach.set_start(1'b1);
		repeat (8) @(posedge pclk);
		apb(1'b1, hcs_pkg::OFS_TEMP, {2'h0, 10'h000, 10'h031, 10'h0c8});
		repeat (2) @(posedge pclk);
		chk("pulse on", {31'h0, aux_relay}, 32'h1);
		apb(1'b1, hcs_pkg::OFS_TEMP, {2'h0, 10'h000, 10'h0be, 10'h0c8});
		i_mach.set_start(1'b0);
		i_mach.set_start(1'b1);
		repeat (8) @(posedge pclk);
		chk("pulse cut", {31'h0, aux_relay}, 32'h0);
		i_mach.set_start(1'b0);
		i_mach.pulse_reset(1'b0);
	endtask : t_cool

	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		presetn = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_regs();
		t_alarm();
		t_cycle();
		t_temp();
		t_notimed();
		t_cool();
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
